// >>> verilog/alu_map.svh
// constants for the add-with-carry and and-literal datapath
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH

// ----------------------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------------------
`define ADDC_OPCODE_POS     10
`define ADDC_OPCODE_WIDTH   6
`define ADDC_OPCODE         6'h08
`define ANDL_OPCODE_POS     8
`define ANDL_OPCODE_WIDTH   8
`define ANDL_OPCODE         8'h0B
`define DEST_BIT_POS        9
`define ACCESS_BIT_POS      8
`define FILE_ADDR_POS       0
`define FILE_ADDR_WIDTH     8

// ----------------------------------------------------------------------------
// data memory addressing
// ----------------------------------------------------------------------------
`define DATA_ADDR_WIDTH     14
`define BANK_WIDTH          6
`define INDEXED_LIMIT       8'h5F
`define ACCESS_LOW_BANK     6'h00
`define ACCESS_HIGH_BANK    6'h3F

// ----------------------------------------------------------------------------
// reset values and the digit carry limit
// ----------------------------------------------------------------------------
`define WORK_RESET          8'h00
`define FLAGS_RESET         5'h00
`define ADDR_RESET          14'h0000
`define BYTE_RESET          8'h00
`define NIBBLE_MAX          5'h0F

`endif

// >>> verilog/alu_pkg.sv
// types shared by the add-with-carry and and-literal datapath
package alu_pkg;

   // ----------------------------------------------------------------------------
   // status flags, in the order they are packed
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic negative;
      logic overflowFlag;
      logic zero;
      logic digitCarryFlag;
      logic carry;
   } status_flags_t;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_ADD_ACCUMULATOR_CARRY_TO_FILE,
      OP_AND_LITERAL_INTO_ACCUMULATOR,
      OP_UNSUPPORTED
   } alu_op_t;

   typedef enum logic [1:0] {
      MODE_ACCESS,
      MODE_BANKED,
      MODE_INDEXED
   } addr_mode_t;

   typedef struct packed {
      logic        enable;
      logic [13:0] addr;
      logic [7:0]  data;
   } mem_write_t;

endpackage

// >>> verilog/operand_addr_gen.sv
// forms the data memory operand address of a file-register instruction
`timescale 1ns/1ps
`include "alu_map.svh"

module operand_addr_gen (
   input  wire logic [`FILE_ADDR_WIDTH-1:0] fileAddr,
   input  wire logic                        accessSel,
   input  wire logic [`BANK_WIDTH-1:0]      bankSelectRegister,
   input  wire logic                        extendedSetEnable,
   input  wire logic [`DATA_ADDR_WIDTH-1:0] indexBase,
   output logic      [`DATA_ADDR_WIDTH-1:0] operandAddr,
   output alu_pkg::addr_mode_t              addrMode
);

   always_comb
   begin
      if (!accessSel && extendedSetEnable && fileAddr <= `INDEXED_LIMIT)
      begin
         // offset wraps within data space; the index pointer owns the range
         operandAddr = indexBase + {{(`DATA_ADDR_WIDTH-`FILE_ADDR_WIDTH){1'b0}}, fileAddr};
         addrMode    = alu_pkg::MODE_INDEXED;
      end
      else if (!accessSel)
      begin
         // bank select register is not consulted here
         if (fileAddr <= `INDEXED_LIMIT)
            operandAddr = {`ACCESS_LOW_BANK, fileAddr};
         else
            operandAddr = {`ACCESS_HIGH_BANK, fileAddr};
         addrMode = alu_pkg::MODE_ACCESS;
      end
      else
      begin
         operandAddr = {bankSelectRegister, fileAddr};
         addrMode    = alu_pkg::MODE_BANKED;
      end
   end

endmodule // operand_addr_gen

// >>> verilog/add_carry_and_literal_alu.sv
// two-stage datapath for add-with-carry-to-file and and-literal-into-accumulator
//
// Operation
// - add_accumulator_carry_to_file sums the working register, the addressed byte and carry, updating N, OV, C, DC, Z.
// - with the access selector at zero the operand comes from the access bank and the bank select register is ignored.
// - indexed literal offset addressing replaces access-bank addressing when the extended set is on, a is zero and f is at most 95.
// - and_literal_into_accumulator ands the working register with the literal into the working register, updating only N and Z.
`timescale 1ns/1ps
`include "alu_map.svh"

module add_carry_and_literal_alu (
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   input  wire logic                        instrValid,
   input  wire logic [15:0]                 instrWord,
   input  wire logic                        extendedSetEnable,
   input  wire logic [`BANK_WIDTH-1:0]      bankSelectRegister,
   input  wire logic [`DATA_ADDR_WIDTH-1:0] indexBase,
   input  wire logic [7:0]                  memReadData,
   input  wire logic                        workLoadEn,
   input  wire logic [7:0]                  workLoadValue,
   input  wire logic                        flagsLoadEn,
   input  alu_pkg::status_flags_t           flagsLoadValue,
   output logic      [7:0]                  workReg,
   output alu_pkg::status_flags_t           statusFlags,
   output logic                             memReadEn,
   output logic      [`DATA_ADDR_WIDTH-1:0] memReadAddr,
   output alu_pkg::mem_write_t              memWrite,
   output logic                             execDone,
   output logic                             opcodeUnsupported,
   output alu_pkg::addr_mode_t              operandMode
);

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   typedef struct packed {
      // decode stage, holds the instruction while its operand is read
      alu_pkg::alu_op_t         exOp;
      logic                     exDest;
      logic [7:0]               exLiteral;
      logic [13:0]              exAddr;
      alu_pkg::addr_mode_t      exMode;
      // architectural and output state
      logic [7:0]               work;
      alu_pkg::status_flags_t   flags;
      alu_pkg::mem_write_t      wr;
      // operand read strobe, registered so the memory sees a clean flop output
      logic                     readEn;
      logic                     done;
      logic                     unsupported;
   } alu_state_t;

   alu_state_t state_reg;
   alu_state_t state_next;

   logic [`DATA_ADDR_WIDTH-1:0] decodeAddr;
   alu_pkg::addr_mode_t         decodeMode;
   alu_pkg::alu_op_t            decodeOp;
   logic [7:0]                  operand;
   logic [8:0]                  sum;
   logic [4:0]                  lowSum;
   logic [7:0]                  andResult;

   // ----------------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------------
   function automatic alu_pkg::alu_op_t decode_op(input logic valid, input logic [15:0] word);
      alu_pkg::alu_op_t op;
      op = alu_pkg::OP_NONE;
      if (valid)
      begin
         if (word[15:`ADDC_OPCODE_POS] == `ADDC_OPCODE)
            op = alu_pkg::OP_ADD_ACCUMULATOR_CARRY_TO_FILE;
         else if (word[15:`ANDL_OPCODE_POS] == `ANDL_OPCODE)
            op = alu_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR;
         else
            op = alu_pkg::OP_UNSUPPORTED;
      end
      return op;
   endfunction

   // zero test shared by the flag updates of both instructions
   function automatic logic is_zero(input logic [7:0] value);
      return value == `BYTE_RESET;
   endfunction

   assign decodeOp = decode_op(instrValid, instrWord);

   operand_addr_gen addrGen (
      .fileAddr           (instrWord[`FILE_ADDR_WIDTH-1:0]),
      .accessSel          (instrWord[`ACCESS_BIT_POS]),
      .bankSelectRegister (bankSelectRegister),
      .extendedSetEnable  (extendedSetEnable),
      .indexBase          (indexBase),
      .operandAddr        (decodeAddr),
      .addrMode           (decodeMode)
   );

   // ----------------------------------------------------------------------------
   // execute arithmetic
   // ----------------------------------------------------------------------------
   // a write issued by the previous instruction has not reached memory when
   // this operand was read, so it is forwarded to avoid a stale byte
   always_comb
   begin
      if (state_reg.wr.enable && state_reg.wr.addr == state_reg.exAddr)
         operand = state_reg.wr.data;
      else
         operand = memReadData;
   end

   always_comb
   begin
      sum       = {1'b0, state_reg.work} + {1'b0, operand} + {8'h00, state_reg.flags.carry};
      lowSum    = {1'b0, state_reg.work[3:0]} + {1'b0, operand[3:0]} + {4'h0, state_reg.flags.carry};
      andResult = state_reg.work & state_reg.exLiteral;
   end

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      state_next             = state_reg;
      state_next.done        = 1'b0;
      state_next.unsupported = 1'b0;
      state_next.wr.enable   = 1'b0;

      // decode stage: capture the instruction and issue the operand read
      state_next.exOp      = decodeOp;
      state_next.exDest    = instrWord[`DEST_BIT_POS];
      state_next.exLiteral = instrWord[7:0];
      state_next.exAddr    = decodeAddr;
      state_next.exMode    = decodeMode;
      // only the add reads memory; the literal form carries its operand in the word
      state_next.readEn    = decodeOp == alu_pkg::OP_ADD_ACCUMULATOR_CARRY_TO_FILE;

      // execute stage
      // flags an instruction does not name keep their value
      case (state_reg.exOp)
         alu_pkg::OP_ADD_ACCUMULATOR_CARRY_TO_FILE:
         begin
            state_next.flags.negative       = sum[7];
            state_next.flags.zero           = is_zero(sum[7:0]);
            state_next.flags.carry          = sum[8];
            state_next.flags.digitCarryFlag = lowSum > `NIBBLE_MAX;
            state_next.flags.overflowFlag   = (state_reg.work[7] == operand[7]) && (sum[7] != operand[7]);
            if (state_reg.exDest)
            begin
               state_next.wr.enable = 1'b1;
               state_next.wr.addr   = state_reg.exAddr;
               state_next.wr.data   = sum[7:0];
            end
            else
               state_next.work = sum[7:0];
            state_next.done = 1'b1;
         end
         alu_pkg::OP_AND_LITERAL_INTO_ACCUMULATOR:
         begin
            state_next.work           = andResult;
            state_next.flags.negative = andResult[7];
            state_next.flags.zero     = is_zero(andResult);
            state_next.done           = 1'b1;
         end
         // an unknown opcode leaves work, flags and memory alone
         alu_pkg::OP_UNSUPPORTED:
            state_next.unsupported = 1'b1;
         default:
            state_next.done = 1'b0;
      endcase

      // the decoder's own loads arrive between our instructions; ours win a tie
      if (workLoadEn && !state_next.done)
         state_next.work = workLoadValue;
      if (flagsLoadEn && !state_next.done)
         state_next.flags = flagsLoadValue;
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg.exOp        <= alu_pkg::OP_NONE;
         state_reg.exDest      <= 1'b0;
         state_reg.exLiteral   <= `BYTE_RESET;
         state_reg.exAddr      <= `ADDR_RESET;
         state_reg.exMode      <= alu_pkg::MODE_ACCESS;
         state_reg.work        <= `WORK_RESET;
         state_reg.flags       <= `FLAGS_RESET;
         state_reg.wr.enable   <= 1'b0;
         state_reg.wr.addr     <= `ADDR_RESET;
         state_reg.wr.data     <= `BYTE_RESET;
         state_reg.readEn      <= 1'b0;
         state_reg.done        <= 1'b0;
         state_reg.unsupported <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   // every output is a plain copy of a state flop, no logic on the way out
   always_comb
   begin
      workReg           = state_reg.work;
      statusFlags       = state_reg.flags;
      memReadEn         = state_reg.readEn;
      memReadAddr       = state_reg.exAddr;
      memWrite          = state_reg.wr;
      execDone          = state_reg.done;
      opcodeUnsupported = state_reg.unsupported;
      operandMode       = state_reg.exMode;
   end

endmodule // add_carry_and_literal_alu

// >>> sim/data_memory_model.sv
// data memory model answering the operand reads of the datapath
`timescale 1ns/1ps
module data_memory_model (
   input  wire logic        core_clk,
   input  wire logic        memReadEn,
   input  wire logic [13:0] memReadAddr,
   output logic      [7:0]  memReadData
);
   logic [7:0] lastData_reg = 8'h00;
   // unselected reads show the inverse of the last byte, so a stale sample never matches
   assign memReadData = memReadEn ? (memReadAddr[7:0] ^ {2'h0, memReadAddr[13:8]}) : ~lastData_reg;
   always_ff @(posedge core_clk)
   begin
      lastData_reg <= memReadData;
   end
endmodule // data_memory_model

// >>> sim/alu_checker_sva.sv
// concurrent checks on the ports of the add-carry and and-literal datapath
`timescale 1ns/1ps
module alu_checker_sva (
   input wire logic                   core_clk,
   input wire logic                   reset,
   input wire logic                   instrValid,
   input wire logic [15:0]            instrWord,
   input wire logic                   extendedSetEnable,
   input wire logic [5:0]             bankSelectRegister,
   input wire logic [13:0]            indexBase,
   input wire logic [7:0]             memReadData,
   input wire logic [7:0]             workReg,
   input alu_pkg::status_flags_t      statusFlags,
   input wire logic                   memReadEn,
   input wire logic [13:0]            memReadAddr,
   input alu_pkg::mem_write_t         memWrite,
   input wire logic                   execDone,
   input alu_pkg::addr_mode_t         operandMode
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   wire       isAdd  = instrValid && instrWord[15:10] == 6'h08;
   wire       isAndl = instrValid && instrWord[15:8] == 8'h0B;
   wire [7:0] f      = instrWord[7:0];
   wire       lowF   = f <= 8'h5F;
   // a file write still pending at the read address is the byte the add must see
   wire       fwd    = memWrite.enable && memWrite.addr == memReadAddr;
   wire [7:0] opNow  = fwd ? memWrite.data : memReadData;
   wire [8:0] sumNow = {1'h0, workReg} + {1'h0, opNow} + {8'h00, statusFlags.carry};
   wire [7:0] result = memWrite.enable ? memWrite.data : workReg;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_access_addr: assert property (isAdd && !instrWord[8] && !(extendedSetEnable && lowF) |=>
      operandMode == alu_pkg::MODE_ACCESS && memReadEn && memReadAddr == {$past(lowF) ? 6'h00 : 6'h3F, $past(f)})
      else $error("access bank address wrong");
   chk_bank_addr: assert property (isAdd && instrWord[8] |=>
      operandMode == alu_pkg::MODE_BANKED && memReadAddr == {$past(bankSelectRegister), $past(f)})
      else $error("banked address wrong");
   chk_indexed_addr: assert property (isAdd && !instrWord[8] && extendedSetEnable && lowF |=>
      operandMode == alu_pkg::MODE_INDEXED && memReadAddr == $past(indexBase) + {6'h00, $past(f)})
      else $error("indexed address wrong");
   chk_add_sum: assert property (memReadEn |=> execDone && result == $past(sumNow[7:0]) &&
      statusFlags.carry == $past(sumNow[8]) && statusFlags.negative == $past(sumNow[7]) &&
      statusFlags.zero == ($past(sumNow[7:0]) == 8'h00))
      else $error("add result or flags wrong");
   chk_file_dest: assert property (isAdd && instrWord[9] |-> ##2 memWrite.enable &&
      memWrite.addr == $past(memReadAddr) && workReg == $past(workReg))
      else $error("file destination wrong");
   chk_work_dest: assert property (isAdd && !instrWord[9] |-> ##2 !memWrite.enable)
      else $error("unexpected file write");
   chk_andl_result: assert property (isAndl |-> ##2 execDone && workReg == ($past(workReg) & $past(f, 2)) &&
      statusFlags.zero == (workReg == 8'h00) && statusFlags.negative == workReg[7] &&
      statusFlags.carry == $past(statusFlags.carry) && statusFlags.overflowFlag == $past(statusFlags.overflowFlag))
      else $error("literal and result or flags wrong");
   chk_andl_noread: assert property (isAndl |=> !memReadEn && !memWrite.enable ##1 !memWrite.enable)
      else $error("literal and touched memory");
   cover property (isAdd && instrWord[9]);
   cover property (isAndl ##1 isAndl);
   cover property (isAdd && extendedSetEnable && !instrWord[8] && lowF);
endmodule // alu_checker_sva

bind add_carry_and_literal_alu alu_checker_sva chk (.core_clk, .reset, .instrValid, .instrWord, .extendedSetEnable,
   .bankSelectRegister, .indexBase, .memReadData, .workReg, .statusFlags, .memReadEn, .memReadAddr, .memWrite,
   .execDone, .operandMode);

// >>> sim/add_carry_and_literal_alu_tb.sv
// self-checking bench for the add-carry and and-literal datapath
`timescale 1ns/1ps
module add_carry_and_literal_alu_tb;
   logic                   core_clk = 1'h0;
   logic                   reset = 1'h1;
   logic                   instrValid = 1'h0;
   logic [15:0]            instrWord = 16'h0000;
   logic                   extendedSetEnable = 1'h0;
   logic [5:0]             bankSelectRegister = 6'h00;
   logic [13:0]            indexBase = 14'h0000;
   logic [7:0]             memReadData;
   logic                   workLoadEn = 1'h0;
   logic [7:0]             workLoadValue = 8'h00;
   logic                   flagsLoadEn = 1'h0;
   alu_pkg::status_flags_t flagsLoadValue = 5'h00;
   logic [7:0]             workReg;
   alu_pkg::status_flags_t statusFlags;
   logic                   memReadEn;
   logic [13:0]            memReadAddr;
   alu_pkg::mem_write_t    memWrite;
   logic                   execDone;
   logic                   opcodeUnsupported;
   alu_pkg::addr_mode_t    operandMode;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   int                     cycleCount = 0;

   add_carry_and_literal_alu dut (.core_clk, .reset, .instrValid, .instrWord, .extendedSetEnable,
      .bankSelectRegister, .indexBase, .memReadData, .workLoadEn, .workLoadValue, .flagsLoadEn, .flagsLoadValue,
      .workReg, .statusFlags, .memReadEn, .memReadAddr, .memWrite, .execDone, .opcodeUnsupported, .operandMode);
   data_memory_model mem (.core_clk, .memReadEn, .memReadAddr, .memReadData);

   always #2 core_clk = ~core_clk;
   // the whole run needs about 40 cycles; a hang is cut well after that
   always @(posedge core_clk)
   begin
      cycleCount++;
      if (cycleCount == 3000)
      begin
         fail_count++;
         complete_run;
      end
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [22:0] got, input logic [22:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      if (got !== exp)
         fail_count++;
   endtask
   function automatic logic [7:0] memByte(input logic [13:0] a);
      return a[7:0] ^ {2'h0, a[13:8]};
   endfunction
   // result with flags packed as negative, overflow, zero, digit carry, carry
   function automatic logic [12:0] addExp(input logic [7:0] w, input logic [7:0] v, input logic c);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'h0, w} + {1'h0, v} + {8'h00, c};
      l = {1'h0, w[3:0]} + {1'h0, v[3:0]} + {4'h0, c};
      return {s[7], w[7] == v[7] && s[7] != v[7], s[7:0] == 8'h00, l[4], s[8], s[7:0]};
   endfunction
   task automatic loadState(input logic [7:0] w, input logic [4:0] fl);
      workLoadEn = 1'h1;
      flagsLoadEn = 1'h1;
      workLoadValue = w;
      flagsLoadValue = fl;
      @(posedge core_clk);
      #1;
      workLoadEn = 1'h0;
      flagsLoadEn = 1'h0;
   endtask
   task automatic issue(input logic [15:0] word, input logic [13:0] addr, input alu_pkg::addr_mode_t mode);
      instrValid = 1'h1;
      instrWord = word;
      @(posedge core_clk);
      #1;
      instrValid = 1'h0;
      check({memReadEn, memReadAddr}, {1'h1, addr}, "operand address");
      check(operandMode, mode, "operand mode");
      @(posedge core_clk);
      #1;
      check(execDone, 1'h1, "done pulse");
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_add_access;
      logic [12:0] e;
      bankSelectRegister = 6'h2A;
      loadState(8'h4D, 5'h01);
      e = addExp(8'h4D, 8'h02, 1'h1);
      issue(16'h2002, 14'h0002, alu_pkg::MODE_ACCESS);
      check({statusFlags, workReg}, e, "add into accumulator");
      check(memWrite.enable, 1'h0, "no file write");
      e = addExp(e[7:0], memByte(14'h3F60), e[8]);
      issue(16'h2060, 14'h3F60, alu_pkg::MODE_ACCESS);
      check({statusFlags, workReg}, e, "add with high access byte");
   endtask
   task automatic t_bank_file;
      logic [12:0] e;
      bankSelectRegister = 6'h15;
      loadState(8'h80, 5'h00);
      e = addExp(8'h80, memByte(14'h15A0), 1'h0);
      issue(16'h23A0, 14'h15A0, alu_pkg::MODE_BANKED);
      check(memWrite, {1'h1, 14'h15A0, e[7:0]}, "file write");
      check({statusFlags, workReg}, {e[12:8], 8'h80}, "flags, accumulator kept");
   endtask
   task automatic t_indexed;
      logic [12:0] e;
      extendedSetEnable = 1'h1;
      indexBase = 14'h1234;
      loadState(8'h01, 5'h00);
      e = addExp(8'h01, memByte(14'h1293), 1'h0);
      issue(16'h205F, 14'h1293, alu_pkg::MODE_INDEXED);
      check({statusFlags, workReg}, e, "indexed add");
      issue(16'h2060, 14'h3F60, alu_pkg::MODE_ACCESS);
      issue(16'h2110, 14'h1510, alu_pkg::MODE_BANKED);
      extendedSetEnable = 1'h0;
   endtask
   task automatic t_andl_pair;
      loadState(8'hA3, 5'h1F);
      instrValid = 1'h1;
      instrWord = 16'h0B5F;
      @(posedge core_clk);
      #1;
      instrWord = 16'h0B0C;
      @(posedge core_clk);
      #1;
      instrValid = 1'h0;
      check(memReadEn, 1'h0, "literal reads no memory");
      check({statusFlags, workReg}, {5'h0B, 8'h03}, "first literal and");
      @(posedge core_clk);
      #1;
      check({statusFlags, workReg}, {5'h0F, 8'h00}, "second literal and");
   endtask
   // unknown opcode changes nothing; a load in the completing cycle of a literal and is ignored
   task automatic t_refused;
      loadState(8'h5A, 5'h13);
      instrValid = 1'h1;
      instrWord = 16'hF0F0;
      @(posedge core_clk);
      #1;
      instrValid = 1'h0;
      check(memReadEn, 1'h0, "unknown opcode reads no memory");
      @(posedge core_clk);
      #1;
      check({opcodeUnsupported, execDone, memWrite.enable}, 3'h4, "unknown opcode pulse");
      check({statusFlags, workReg}, {5'h13, 8'h5A}, "unknown opcode changes nothing");
      @(posedge core_clk);
      #1;
      check(opcodeUnsupported, 1'h0, "unknown opcode pulse ends");
      instrValid = 1'h1;
      instrWord = 16'h0BF0;
      @(posedge core_clk);
      #1;
      instrValid = 1'h0;
      workLoadEn = 1'h1;
      workLoadValue = 8'hFF;
      @(posedge core_clk);
      #1;
      workLoadEn = 1'h0;
      check({statusFlags, workReg}, {5'h03, 8'h50}, "load yields to literal and");
   endtask
   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge core_clk);
      #1;
      reset = 1'h0;
      check({workReg, statusFlags, memWrite.enable, execDone}, 15'h0000, "reset state");
      t_add_access;
      t_bank_file;
      t_indexed;
      t_andl_pair;
      t_refused;
      complete_run;
   end
endmodule // add_carry_and_literal_alu_tb
